// >>> design/tcc_pkg.sv
package tcc_pkg;
	// ==========================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMP1 = 8'h04;
	localparam logic [7:0] ADDR_CMP2 = 8'h08;
	localparam logic [7:0] ADDR_CAP1 = 8'h0c;
	localparam logic [7:0] ADDR_CAP2 = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_MASK = 8'h18;
	localparam logic [7:0] ADDR_COUNT = 8'h1c;
	// ==========================================
	// ctrl field positions
	localparam int CTRL_PRESC_LO = 0;
	localparam int CTRL_CMP1_EN = 2;
	localparam int CTRL_CMP2_EN = 3;
	localparam int CTRL_FORCE1 = 4;
	localparam int CTRL_FORCE2 = 5;
	localparam int CTRL_LVL1 = 6;
	localparam int CTRL_LVL2 = 7;
	localparam int CTRL_EDGE1 = 8;
	localparam int CTRL_EDGE2 = 9;
	localparam int CTRL_PWM = 10;
	localparam int CTRL_OPM = 11;
	localparam int CTRL_WIDTH = 12;
	// status / mask bits
	localparam int ST_CMP1 = 0;
	localparam int ST_CMP2 = 1;
	localparam int ST_CAP1 = 2;
	localparam int ST_CAP2 = 3;
	localparam int ST_OVF = 4;
	localparam int ST_WIDTH = 5;
	// ==========================================
	// prescaler select codes and divide counts
	localparam logic [1:0] PRESC_DIV2 = 2'h0;
	localparam logic [1:0] PRESC_DIV4 = 2'h1;
	localparam logic [1:0] PRESC_DIV8 = 2'h2;
	localparam logic [1:0] PRESC_DIV8000 = 2'h3;
	localparam logic [12:0] DIV_2 = 13'h0002;
	localparam logic [12:0] DIV_4 = 13'h0004;
	localparam logic [12:0] DIV_8 = 13'h0008;
	localparam logic [12:0] DIV_8000 = 13'h1f40;
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 12'h001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		TCC_MODE_CMP,
		TCC_MODE_PWM,
		TCC_MODE_OPM
	} tcc_mode_t;

	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} tcc_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tcc_axi_rsp_t;
endpackage

// >>> design/tcc_timer8.sv
module tcc_timer8 (
	input wire logic mclk,
	input wire logic rst,
	input tcc_pkg::tcc_axi_req_t axi_req,
	output tcc_pkg::tcc_axi_rsp_t axi_rsp,
	input wire logic capture_in_one,
	input wire logic capture_in_two,
	output logic compare_out_one,
	output logic compare_out_two,
	output logic irq,
	output tcc_pkg::tcc_mode_t mode_out
);
	import tcc_pkg::*;

	typedef struct packed {
		tcc_axi_rsp_t rsp;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic [CTRL_WIDTH-1:0] ctrl;
		logic [7:0] compare_value_one;
		logic [7:0] compare_value_two;
		logic [7:0] cap1;
		logic [7:0] cap2;
		logic [ST_WIDTH-1:0] status;
		logic [ST_WIDTH-1:0] mask;
		logic [12:0] presc;
		logic [7:0] count;
		logic [1:0] cap_prev;
		logic out1;
		logic out2;
		logic irq;
		tcc_mode_t mode;
	} tcc_state_t;

	tcc_state_t state_reg;
	tcc_state_t state_next;

	// ==========================================
	// combinational next state
	logic [12:0] div;
	logic tick;
	logic wr;
	logic rd_status;
	logic [ST_WIDTH-1:0] ev;
	logic [1:0] edge_hit;
	logic [1:0] edge_sel;
	logic [1:0] cap_now;
	logic [31:0] rd_val;
	logic rd_ok;
	logic [3:0] wb;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg.ctrl[CTRL_PRESC_LO +: 2])
			PRESC_DIV2: div = DIV_2;
			PRESC_DIV4: div = DIV_4;
			PRESC_DIV8: div = DIV_8;
			PRESC_DIV8000: div = DIV_8000;
		endcase
		tick = (state_reg.presc >= div - 13'h0001);
		ev = '0;

		// prescaler and counter
		state_next.presc = tick ? 13'h0000 : state_reg.presc + 13'h0001;
		if (tick) begin
			state_next.count = state_reg.count + 8'h01;
			ev[ST_OVF] = (state_reg.count == 8'hff);
		end

		// mode: pwm wins over one-pulse
		if (state_reg.ctrl[CTRL_PWM]) begin
			state_next.mode = TCC_MODE_PWM;
		end else if (state_reg.ctrl[CTRL_OPM]) begin
			state_next.mode = TCC_MODE_OPM;
		end else begin
			state_next.mode = TCC_MODE_CMP;
		end

		// compare channels; match counted on tick so one flag per count value
		if (state_reg.ctrl[CTRL_FORCE1]) begin
			state_next.out1 = state_reg.ctrl[CTRL_LVL1];
		end else if (state_reg.ctrl[CTRL_CMP1_EN] && tick
				&& state_reg.count == state_reg.compare_value_one) begin
			state_next.out1 = state_reg.ctrl[CTRL_LVL1];
			ev[ST_CMP1] = 1'b1;
		end
		if (state_reg.ctrl[CTRL_FORCE2]) begin
			state_next.out2 = state_reg.ctrl[CTRL_LVL2];
		end else if (state_reg.ctrl[CTRL_CMP2_EN] && tick
				&& state_reg.count == state_reg.compare_value_two) begin
			state_next.out2 = state_reg.ctrl[CTRL_LVL2];
			ev[ST_CMP2] = 1'b1;
		end

		// capture channels; pins are taken as synchronous
		cap_now = {capture_in_two, capture_in_one};
		edge_sel = {state_reg.ctrl[CTRL_EDGE2], state_reg.ctrl[CTRL_EDGE1]};
		state_next.cap_prev = cap_now;
		for (int i = 0; i < 2; i++) begin
			edge_hit[i] = edge_sel[i] ? (cap_now[i] & ~state_reg.cap_prev[i])
				: (~cap_now[i] & state_reg.cap_prev[i]);
		end
		if (state_reg.ctrl[CTRL_PWM] || state_reg.ctrl[CTRL_OPM]) begin
			edge_hit[0] = 1'b0;
		end
		if (edge_hit[0]) begin
			state_next.cap1 = state_reg.count;
			ev[ST_CAP1] = 1'b1;
		end
		if (edge_hit[1]) begin
			state_next.cap2 = state_reg.count;
			ev[ST_CAP2] = 1'b1;
		end

		// ==========================================
		// axi4-lite write
		if (state_reg.rsp.awready && axi_req.awvalid) begin
			state_next.aw_got = 1'b1;
			state_next.aw_addr = axi_req.awaddr;
			state_next.rsp.awready = 1'b0;
		end
		if (state_reg.rsp.wready && axi_req.wvalid) begin
			state_next.w_got = 1'b1;
			state_next.w_data = axi_req.wdata;
			state_next.w_strb = axi_req.wstrb;
			state_next.rsp.wready = 1'b0;
		end
		wr = state_reg.aw_got && state_reg.w_got && !state_reg.rsp.bvalid;
		wb = state_reg.w_strb;
		if (wr) begin
			state_next.rsp.bvalid = 1'b1;
			state_next.rsp.bresp = RESP_OKAY;
			unique case (state_reg.aw_addr & 8'hfc)
				ADDR_CTRL: begin
					if (wb[0]) state_next.ctrl[7:0] = state_reg.w_data[7:0];
					if (wb[1]) state_next.ctrl[11:8] = state_reg.w_data[11:8];
				end
				ADDR_CMP1: if (wb[0]) state_next.compare_value_one = state_reg.w_data[7:0];
				ADDR_CMP2: if (wb[0]) state_next.compare_value_two = state_reg.w_data[7:0];
				// one write sets any combination of masks
				ADDR_MASK: if (wb[0]) state_next.mask = state_reg.w_data[ST_WIDTH-1:0];
				ADDR_CAP1, ADDR_CAP2, ADDR_STATUS, ADDR_COUNT: ;
				default: state_next.rsp.bresp = RESP_SLVERR;
			endcase
		end
		if (state_reg.rsp.bvalid && axi_req.bready) begin
			state_next.rsp.bvalid = 1'b0;
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.rsp.awready = 1'b1;
			state_next.rsp.wready = 1'b1;
		end

		// ==========================================
		// axi4-lite read
		rd_ok = 1'b1;
		unique case (axi_req.araddr & 8'hfc)
			ADDR_CTRL: rd_val = {20'h00000, state_reg.ctrl};
			ADDR_CMP1: rd_val = {24'h000000, state_reg.compare_value_one};
			ADDR_CMP2: rd_val = {24'h000000, state_reg.compare_value_two};
			ADDR_CAP1: rd_val = {24'h000000, state_reg.cap1};
			ADDR_CAP2: rd_val = {24'h000000, state_reg.cap2};
			ADDR_STATUS: rd_val = {27'h0000000, state_reg.status};
			ADDR_MASK: rd_val = {27'h0000000, state_reg.mask};
			ADDR_COUNT: rd_val = {24'h000000, state_reg.count};
			default: begin
				rd_val = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
		rd_status = 1'b0;
		if (state_reg.rsp.arready && axi_req.arvalid) begin
			state_next.rsp.arready = 1'b0;
			state_next.rsp.rvalid = 1'b1;
			state_next.rsp.rdata = rd_val;
			state_next.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
			rd_status = ((axi_req.araddr & 8'hfc) == ADDR_STATUS);
		end
		if (state_reg.rsp.rvalid && axi_req.rready) begin
			state_next.rsp.rvalid = 1'b0;
			state_next.rsp.arready = 1'b1;
		end

		// read clears status; a same-cycle event still lands
		state_next.status = (rd_status ? '0 : state_reg.status) | ev;
		state_next.irq = |(state_next.status & state_next.mask);
	end

	// ==========================================
	// state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.ctrl <= CTRL_RESET;
			state_reg.mode <= TCC_MODE_CMP;
			// pins rest high; a zero here would fake a rising edge after reset
			state_reg.cap_prev <= 2'h3;
			state_reg.rsp.awready <= 1'b1;
			state_reg.rsp.wready <= 1'b1;
			state_reg.rsp.arready <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign axi_rsp = state_reg.rsp;
	assign compare_out_one = state_reg.out1;
	assign compare_out_two = state_reg.out2;
	assign irq = state_reg.irq;
	assign mode_out = state_reg.mode;
endmodule

// >>> testbench/tcc_timer8_sva.sv
module tcc_sva (
	input wire logic mclk,
	input wire logic rst,
	input tcc_pkg::tcc_axi_req_t axi_req,
	input tcc_pkg::tcc_axi_rsp_t axi_rsp,
	input wire logic capture_in_one,
	input wire logic capture_in_two,
	input wire logic compare_out_one,
	input wire logic compare_out_two,
	input wire logic irq,
	input tcc_pkg::tcc_mode_t mode_out
);
	import tcc_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ==========================================
	// cycles since the last bus request was taken
	logic [2:0] quiet_reg;
	always_ff @(posedge mclk) begin
		if (rst || axi_req.arvalid && axi_rsp.arready || axi_req.awvalid && axi_rsp.awready)
			quiet_reg <= 3'h0;
		else if (quiet_reg != 3'h7)
			quiet_reg <= quiet_reg + 3'h1;
	end
	sequence s_wr_take;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	sequence s_wr_free;
		!axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready;
	endsequence
	property p_b_lat; s_wr_take |-> ##[1:2] axi_rsp.bvalid; endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	property p_b_done; axi_rsp.bvalid && axi_req.bready |=> s_wr_free; endproperty
	a_b_done: assert property (p_b_done) else $error("write channel not freed");
	property p_aw_busy; axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready; endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("write ready while answering");
	property p_r_lat; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read data late");
	property p_r_done; axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid; endproperty
	a_r_done: assert property (p_r_done) else $error("read data held too long");
	property p_ar_busy; axi_rsp.rvalid |-> !axi_rsp.arready; endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read ready while answering");
	property p_irq_fall; $fell(irq) |-> quiet_reg < 3'h5; endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
	property p_mode; $changed(mode_out) |-> quiet_reg < 3'h5; endproperty
	a_mode: assert property (p_mode) else $error("mode changed without access");
endmodule
bind tcc_timer8 tcc_sva tcc_sva_i (.mclk(mclk), .rst(rst), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .capture_in_one(capture_in_one), .capture_in_two(capture_in_two),
	.compare_out_one(compare_out_one), .compare_out_two(compare_out_two), .irq(irq),
	.mode_out(mode_out));

// >>> testbench/tcc_pins.sv
module tcc_pins (
	input wire logic mclk,
	output logic capture_in_one,
	output logic capture_in_two
);
	timeunit 1ns;
	timeprecision 1ps;
	// pins rest high as pulled-up inputs with no port interrupt behind them
	initial begin
		capture_in_one = 1'b1;
		capture_in_two = 1'b1;
	end
	task automatic put(input logic one, input logic two);
		@(posedge mclk);
		capture_in_one <= one;
		capture_in_two <= two;
	endtask
endmodule

// >>> testbench/tcc_timer8_tb.sv
module tcc_timer8_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tcc_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	tcc_axi_req_t req = '0;
	tcc_axi_rsp_t rsp;
	logic cap1, cap2, out1, out2, irq;
	logic [2:0] outs;
	tcc_mode_t mode;
	int bad_count = 0;
	int checks = 0;
	logic [31:0] d;
	logic [1:0] r;
	logic [7:0] c;
	assign outs = {irq, out2, out1};
	initial forever #10 mclk = ~mclk;
	tcc_timer8 tcc_timer8_i (.mclk(mclk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
		.capture_in_one(cap1), .capture_in_two(cap2), .compare_out_one(out1),
		.compare_out_two(out2), .irq(irq), .mode_out(mode));
	tcc_pins tcc_pins_i (.mclk(mclk), .capture_in_one(cap1), .capture_in_two(cap2));
	// ==========================================
	// tasks
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic hang;
		bad_count++;
		report_and_stop();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge mclk);
		req.awaddr <= a;
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 50 && rsp.bvalid !== 1'b1; n++) begin
			@(posedge mclk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end
		if (n == 50)
			hang();
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge mclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 50 && rsp.rvalid !== 1'b1; n++) begin
			@(posedge mclk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end
		if (n == 50)
			hang();
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		rd(a);
		chk("register", exp, d & m);
	endtask
	task automatic wait_hi(input int k, input int lim);
		int n;
		for (n = 0; n < lim && outs[k] !== 1'b1; n++)
			@(posedge mclk);
		if (n == lim)
			hang();
	endtask
	// ==========================================
	// scenarios
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		rchk(ADDR_CTRL, 32'h001, 32'hfff);
		rd(8'h40);
		chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(8'h40, 32'h0);
		chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, r});
		// reads 16 cycles apart at divide-by-8 must see exactly two ticks
		wr(ADDR_CTRL, 32'h002);
		rd(ADDR_COUNT);
		c = d[7:0];
		repeat (13) @(posedge mclk);
		rd(ADDR_COUNT);
		chk("count step", 32'h2, {24'h0, d[7:0] - c});
		wr(ADDR_MASK, 32'h1f);
		chk("wr resp", {30'h0, RESP_OKAY}, {30'h0, r});
		wr(ADDR_CMP1, 32'hfc);
		wr(ADDR_CTRL, 32'h044);
		wait_hi(0, 600);
		wait_hi(2, 3);
		rchk(ADDR_STATUS, 32'h1, 32'h3);
		wr(ADDR_CTRL, 32'h0a0);
		wait_hi(1, 5);
		wr(ADDR_CTRL, 32'h020);
		repeat (3) @(posedge mclk);
		chk("out pair", 32'h1, {30'h0, out2, out1});
		rchk(ADDR_STATUS, 32'h0, 32'h3);
		wr(ADDR_CMP2, 32'h10);
		wr(ADDR_CTRL, 32'h088);
		wait_hi(1, 600);
		rchk(ADDR_STATUS, 32'h2, 32'h3);
		// divide-by-8000 freezes the counter for the capture checks
		wr(ADDR_CTRL, 32'h103);
		tcc_pins_i.put(1'b0, 1'b1);
		wr(ADDR_MASK, 32'h0);
		rd(ADDR_STATUS);
		tcc_pins_i.put(1'b1, 1'b0);
		repeat (3) @(posedge mclk);
		chk("irq", 32'h0, {31'h0, irq});
		rchk(ADDR_STATUS, 32'hc, 32'hc);
		rd(ADDR_COUNT);
		c = d[7:0];
		rchk(ADDR_CAP1, {24'h0, c}, 32'hff);
		rchk(ADDR_CAP2, {24'h0, c}, 32'hff);
		tcc_pins_i.put(1'b0, 1'b1);
		rchk(ADDR_STATUS, 32'h0, 32'hc);
		wr(ADDR_MASK, 32'h4);
		tcc_pins_i.put(1'b1, 1'b1);
		wait_hi(2, 5);
		wr(ADDR_CTRL, 32'h500);
		tcc_pins_i.put(1'b0, 1'b1);
		rd(ADDR_STATUS);
		tcc_pins_i.put(1'b1, 1'b1);
		rchk(ADDR_STATUS, 32'h0, 32'h4);
		chk("mode", TCC_MODE_PWM, {30'h0, mode});
		wr(ADDR_CTRL, 32'h800);
		rd(ADDR_CTRL);
		chk("mode", TCC_MODE_OPM, {30'h0, mode});
		wr(ADDR_CTRL, 32'hc00);
		rd(ADDR_CTRL);
		chk("mode", TCC_MODE_PWM, {30'h0, mode});
		wr(ADDR_MASK, 32'h10);
		rd(ADDR_STATUS);
		wait_hi(2, 600);
		rchk(ADDR_STATUS, 32'h10, 32'h10);
		report_and_stop();
	end
endmodule
